// ---- rtl/wdst_consts.vh ----
// Constants for the watchdog and start-up timer block
`ifndef WDST_CONSTS_VH
`define WDST_CONSTS_VH

// ****************************************
// Clock and timing
// ****************************************
`define WDST_CLK_MHZ 100
`define WDST_WDT_PERIOD_MS 18
`define WDST_PWRUP_INTERVAL_MS 72
`define WDST_OSC_STARTUP_CYCLES 1024
`define WDST_WDT_RESET_CYCLES 1
`define WDST_BOOT_CYCLES 3

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define WDST_OPT_IDX 14'h0081
`define WDST_CFG_IDX 14'h2007
`define WDST_CTRL_IDX 14'h2008
`define WDST_STAT_IDX 14'h2009
`define WDST_IRQ_STS_IDX 14'h200A
`define WDST_IRQ_EN_IDX 14'h200B
`define WDST_IRQ_CLR_IDX 14'h200C

// ****************************************
// Field positions and reset values
// ****************************************
`define WDST_CFG_PWRUP_EN_BIT 3
`define WDST_CFG_WDT_EN_BIT 2
`define WDST_OPT_PSA_BIT 3
`define WDST_OPT_RESET 8'hFF
`define WDST_CTRL_WATCHDOG_CLEAR_INSTR_BIT 0
`define WDST_CTRL_SLEEP_BIT 1
`define WDST_CTRL_WAKE_BIT 2
`define WDST_IRQ_TIMEOUT_BIT 0
`define WDST_IRQ_WAKE_BIT 1
`define WDST_IRQ_START_BIT 2
`define WDST_MODE_LP 2'h0
`define WDST_MODE_XT 2'h1
`define WDST_MODE_HS 2'h2

`endif

// ---- rtl/wdst_rc_tick.v ----
// Free-running interval tick standing in for the internal RC oscillator
`timescale 1ns/100ps
`default_nettype none

module wdst_rc_tick #(
    parameter [31:0] PERIOD = 32'd1800000
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire run,
    input wire clr,
    // Result
    output reg tick
);

reg [31:0] cnt_r;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_r <= 32'h0000_0000;
        tick <= 1'b0;
    end else if (!run || clr) begin
        cnt_r <= 32'h0000_0000;
        tick <= 1'b0;
    end else if (cnt_r == PERIOD - 32'd1) begin
        cnt_r <= 32'h0000_0000;
        tick <= 1'b1;
    end else begin
        cnt_r <= cnt_r + 32'd1;
        tick <= 1'b0;
    end
end

endmodule
`default_nettype wire

// ---- rtl/wdst_top.v ----
// Watchdog, power-up delay and oscillator start-up delay with APB registers
`timescale 1ns/100ps
`default_nettype none
`include "wdst_consts.vh"

//
// Overview of operation
// - Hold reset 1024 oscillator cycles after power-up in crystal modes
// - Start-up delay only crystal modes, POR/wake
// - Watchdog on own RC tick, runs asleep
// - Timeout while running gives full device reset
// - Timeout while asleep wakes the device
// - Enable fuse zero disables watchdog forever
// - Base timeout period is 18 ms
// - Option register assigns prescaler up to 1:128
// - Clear or sleep resets counter and prescaler
// - Every timeout clears the timeout flag
// - Config bits: powerup, watchdog, two mode
// - Option: assign bit3, rate 2:0, resets ones
// - Power-on holds reset for 72 ms
// - Power-up delay follows its enable bit
module wdst_top #(
    parameter [31:0] WDT_BASE_CYC = `WDST_WDT_PERIOD_MS * 1000 * `WDST_CLK_MHZ,
    parameter [31:0] PWRUP_CYC = `WDST_PWRUP_INTERVAL_MS * 1000 * `WDST_CLK_MHZ,
    parameter [10:0] OST_CYC = `WDST_OSC_STARTUP_CYCLES
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Pins
    input wire osc_input_pin,
    input wire [3:0] cfg_word_pins,
    // Device status
    output reg device_reset_r,
    output reg asleep_r,
    output reg irq
);

// ****************************************
// States
// ****************************************
localparam [2:0] S_BOOT = 3'd0;
localparam [2:0] S_PWRUP = 3'd1;
localparam [2:0] S_OST = 3'd2;
localparam [2:0] S_RUN = 3'd3;
localparam [2:0] S_SLEEP = 3'd4;
localparam [2:0] S_WRST = 3'd5;

// ****************************************
// Helpers
// ****************************************
function [6:0] rate_mask;
    input [2:0] rate;
    begin
        rate_mask = 7'h7F >> (3'd7 - rate);
    end
endfunction

function is_crystal;
    input [1:0] mode;
    begin
        is_crystal = (mode == `WDST_MODE_LP) || (mode == `WDST_MODE_XT) ||
                     (mode == `WDST_MODE_HS);
    end
endfunction

// ****************************************
// Declarations
// ****************************************
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [1:0] boot_cnt_r;
reg [10:0] ost_cnt_r;
reg [6:0] pre_cnt_r;
reg [7:0] opt_r;
reg [3:0] cfg_r;
reg [3:0] cfg_s1_r;
reg [3:0] cfg_s2_r;
reg osc_s1_r;
reg osc_s2_r;
reg osc_s3_r;
reg timeout_flag_r;
reg powerdown_flag_r;
reg [2:0] irq_sts_r;
reg [2:0] irq_en_r;
reg [2:0] irq_set;
reg [2:0] irq_clr;
reg [31:0] rd_val;
reg rd_hit;
wire wdt_tick;
wire pwrup_tick;
wire osc_edge;
wire acc;
wire wr;
wire [15:0] a;
wire wdt_en;
wire wdt_run;
wire wdt_clr;
wire wdt_to;
wire watchdog_clear_instr_cmd;
wire sleep_cmd;
wire wake_cmd;
wire crystal;

// ****************************************
// Pin synchronisers
// ****************************************
// Fuse pins and the oscillator input are asynchronous to pclk
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_s1_r <= 4'h0;
        cfg_s2_r <= 4'h0;
        osc_s1_r <= 1'b0;
        osc_s2_r <= 1'b0;
        osc_s3_r <= 1'b0;
    end else begin
        cfg_s1_r <= cfg_word_pins;
        cfg_s2_r <= cfg_s1_r;
        osc_s1_r <= osc_input_pin;
        osc_s2_r <= osc_s1_r;
        osc_s3_r <= osc_s2_r;
    end
end

assign osc_edge = osc_s2_r & ~osc_s3_r;
assign crystal = is_crystal(cfg_r[1:0]);

// ****************************************
// APB decode
// ****************************************
assign acc = psel & penable & pready;
assign wr = acc & pwrite;
assign a = paddr;
assign watchdog_clear_instr_cmd = wr && (a == {`WDST_CTRL_IDX, 2'b00}) && pwdata[`WDST_CTRL_WATCHDOG_CLEAR_INSTR_BIT];
assign sleep_cmd = wr && (a == {`WDST_CTRL_IDX, 2'b00}) && pwdata[`WDST_CTRL_SLEEP_BIT];
assign wake_cmd = wr && (a == {`WDST_CTRL_IDX, 2'b00}) && pwdata[`WDST_CTRL_WAKE_BIT];

always @* begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (a == {`WDST_OPT_IDX, 2'b00}) begin
        rd_val = {24'h000000, opt_r};
    end else if (a == {`WDST_CFG_IDX, 2'b00}) begin
        rd_val = {28'h0000000, cfg_r};
    end else if (a == {`WDST_CTRL_IDX, 2'b00}) begin
        rd_val = 32'h0000_0000;
    end else if (a == {`WDST_STAT_IDX, 2'b00}) begin
        rd_val = {26'h0000000, wdt_run, device_reset_r, asleep_r, state_r == S_SLEEP,
                  powerdown_flag_r, timeout_flag_r};
    end else if (a == {`WDST_IRQ_STS_IDX, 2'b00}) begin
        rd_val = {29'h00000000, irq_sts_r};
    end else if (a == {`WDST_IRQ_EN_IDX, 2'b00}) begin
        rd_val = {29'h00000000, irq_en_r};
    end else if (a == {`WDST_IRQ_CLR_IDX, 2'b00}) begin
        rd_val = 32'h0000_0000;
    end else begin
        rd_hit = 1'b0;
    end
end

// Zero-wait slave: answer is ready in the first access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        pready <= psel & ~penable;
        if (psel && !penable) begin
            pslverr <= ~rd_hit;
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
        end
    end
end

// ****************************************
// Watchdog counting
// ****************************************
assign wdt_en = cfg_r[`WDST_CFG_WDT_EN_BIT];
// Keeps counting in sleep, the main oscillator plays no part
assign wdt_run = wdt_en && ((state_r == S_RUN) || (state_r == S_SLEEP));
assign wdt_clr = watchdog_clear_instr_cmd || (sleep_cmd && state_r == S_RUN) || wdt_to;

wdst_rc_tick #(
    .PERIOD(WDT_BASE_CYC)
) u_wdt_base (
    .pclk(pclk),
    .presetn(presetn),
    .run(wdt_run),
    .clr(wdt_clr),
    .tick(wdt_tick)
);

wdst_rc_tick #(
    .PERIOD(PWRUP_CYC)
) u_pwrup (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_r == S_PWRUP),
    .clr(1'b0),
    .tick(pwrup_tick)
);

// Prescaler only matters when assigned; otherwise each base tick expires
assign wdt_to = wdt_run && wdt_tick &&
                (!opt_r[`WDST_OPT_PSA_BIT] || (pre_cnt_r == rate_mask(opt_r[2:0])));

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pre_cnt_r <= 7'h00;
    end else if (wdt_clr || !wdt_run || !opt_r[`WDST_OPT_PSA_BIT]) begin
        pre_cnt_r <= 7'h00;
    end else if (wdt_tick) begin
        pre_cnt_r <= pre_cnt_r + 7'h01;
    end
end

// ****************************************
// Reset and sleep sequencing
// ****************************************
always @* begin
    state_nxt = state_r;
    case (state_r)
        S_BOOT: begin
            if (boot_cnt_r == `WDST_BOOT_CYCLES) begin
                // Skipped when the fuse does not ask for it
                if (cfg_s2_r[`WDST_CFG_PWRUP_EN_BIT]) begin
                    state_nxt = S_PWRUP;
                end else if (is_crystal(cfg_s2_r[1:0])) begin
                    state_nxt = S_OST;
                end else begin
                    state_nxt = S_RUN;
                end
            end
        end
        S_PWRUP: begin
            if (pwrup_tick) begin
                state_nxt = crystal ? S_OST : S_RUN;
            end
        end
        S_OST: begin
            if (osc_edge && ost_cnt_r == OST_CYC - 11'd1) begin
                state_nxt = S_RUN;
            end
        end
        S_RUN: begin
            if (wdt_to) begin
                state_nxt = S_WRST;
            end else if (sleep_cmd) begin
                state_nxt = S_SLEEP;
            end
        end
        S_SLEEP: begin
            if (wdt_to || wake_cmd) begin
                state_nxt = crystal ? S_OST : S_RUN;
            end
        end
        S_WRST: begin
            // No start-up delay after a watchdog reset
            state_nxt = S_RUN;
        end
        default: begin
            state_nxt = S_BOOT;
        end
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_r <= S_BOOT;
        boot_cnt_r <= 2'h0;
        ost_cnt_r <= 11'h000;
        cfg_r <= 4'h0;
        device_reset_r <= 1'b1;
        asleep_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        if (state_r == S_BOOT) begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
            cfg_r <= cfg_s2_r;
        end
        if (state_r != S_OST) begin
            ost_cnt_r <= 11'h000;
        end else if (osc_edge) begin
            ost_cnt_r <= ost_cnt_r + 11'h001;
        end
        device_reset_r <= (state_nxt != S_RUN) && (state_nxt != S_SLEEP);
        asleep_r <= state_nxt == S_SLEEP;
    end
end

// ****************************************
// Option register and status flags
// ****************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        opt_r <= `WDST_OPT_RESET;
        timeout_flag_r <= 1'b1;
        powerdown_flag_r <= 1'b1;
    end else begin
        if (state_r == S_RUN && wdt_to) begin
            opt_r <= `WDST_OPT_RESET;
        end else if (wr && a == {`WDST_OPT_IDX, 2'b00}) begin
            opt_r <= pwdata[7:0];
        end
        if (wdt_to) begin
            timeout_flag_r <= 1'b0;
            powerdown_flag_r <= state_r != S_SLEEP;
        end else if (watchdog_clear_instr_cmd) begin
            timeout_flag_r <= 1'b1;
            powerdown_flag_r <= 1'b1;
        end else if (sleep_cmd && state_r == S_RUN) begin
            timeout_flag_r <= 1'b1;
            powerdown_flag_r <= 1'b0;
        end
    end
end

// ****************************************
// Interrupts
// ****************************************
always @* begin
    irq_set = 3'h0;
    irq_set[`WDST_IRQ_TIMEOUT_BIT] = wdt_to;
    irq_set[`WDST_IRQ_WAKE_BIT] = (state_r == S_SLEEP) && (state_nxt != S_SLEEP);
    irq_set[`WDST_IRQ_START_BIT] = (state_r != S_RUN) && (state_r != S_SLEEP) &&
                                   (state_r != S_WRST) && (state_nxt == S_RUN);
    irq_clr = (wr && a == {`WDST_IRQ_CLR_IDX, 2'b00}) ? pwdata[2:0] : 3'h0;
end

// Set beats clear so an event in the clearing cycle survives
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_sts_r <= 3'h0;
        irq_en_r <= 3'h0;
        irq <= 1'b0;
    end else begin
        irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_set;
        if (wr && a == {`WDST_IRQ_EN_IDX, 2'b00}) begin
            irq_en_r <= pwdata[2:0];
        end
        irq <= |(((irq_sts_r & ~irq_clr) | irq_set) & irq_en_r);
    end
end

endmodule
`default_nettype wire

// ---- sim/wdst_checker_properties.sv ----
// Port assertions for the watchdog and start-up timer
`timescale 1ns/100ps
`default_nettype none
// ****************
// Checker
// ****************
module wdst_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Status
    input wire logic device_reset_r,
    input wire logic asleep_r
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    bus_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    bus_single_a: assert property (pready |=> !pready)
        else $error("answer held too long");
    boot_hold_a: assert property ($rose(presetn) |-> device_reset_r [*4])
        else $error("reset left too early");
    wdt_pulse_a: assert property ($rose(device_reset_r) && !$past(asleep_r) |=> !device_reset_r)
        else $error("watchdog reset not one cycle");
    sleep_quiet_a: assert property (asleep_r |-> !device_reset_r)
        else $error("reset while asleep");
    opt_width_a: assert property (pready && !pwrite && paddr == 16'h0204 |-> prdata[31:8] == 24'h0)
        else $error("option upper bits set");
    cfg_width_a: assert property (pready && !pwrite && paddr == 16'h801C |-> prdata[31:4] == 28'h0)
        else $error("config upper bits set");
    bad_addr_a: assert property (pready && !pwrite && paddr == 16'h0300 |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind wdst_top wdst_checker u_wdst_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .device_reset_r, .asleep_r);
`default_nettype wire

// ---- sim/wdst_osc_model.sv ----
// Free-running crystal oscillator source
`timescale 1ns/100ps
`default_nettype none
// ****************
// Oscillator
// ****************
module wdst_osc_model (
    // Oscillator pin
    output logic osc
);
    // Period of four bus clocks keeps start-up counts short
    initial begin
        osc = 1'b0;
        forever #20 osc = ~osc;
    end
endmodule
`default_nettype wire

// ---- sim/test_watchdog_and_startup_timer.sv ----
// Self-checking bench for the watchdog and start-up timer
`timescale 1ns/100ps
`default_nettype none
// ****************
// Bench
// ****************
module test_watchdog_and_startup_timer;
    localparam logic [31:0] BASE = 32'h32;
    localparam logic [31:0] PWR = 32'h28;
    localparam logic [10:0] OSTN = 11'h400;
    localparam logic [15:0] OPT = 16'h0204;
    localparam logic [15:0] CFG = 16'h801C;
    localparam logic [15:0] CTRL = 16'h8020;
    localparam logic [15:0] STAT = 16'h8024;
    localparam logic [15:0] IEN = 16'h802C;
    localparam logic [15:0] ICLR = 16'h8030;
    logic pclk, presetn, psel, penable, pwrite, osc, pready, pslverr;
    logic device_reset_r, asleep_r, irq, er;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] cfg_word_pins;
    logic [3:0] cfgs [0:5];
    integer err_count, comparisons, n, i, lo;
    wdst_osc_model u_osc (.osc);
    wdst_top #(.WDT_BASE_CYC(BASE), .PWRUP_CYC(PWR), .OST_CYC(OSTN)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .osc_input_pin(osc), .cfg_word_pins,
        .device_reset_r, .asleep_r, .irq
    );
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // Only the hang guard ends a wait for the answer
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task span(input integer a, input integer b);
        begin
            comparisons = comparisons + 1;
            if (n < a || n > b) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: %0d cycles", $time, n);
            end
        end
    endtask
    task hold(input logic v, input integer lim);
        begin
            n = 0;
            while (device_reset_r !== v && n < lim) begin
                @(posedge pclk);
                n = n + 1;
            end
        end
    endtask
    task boot(input logic [3:0] c);
        begin
            @(posedge pclk);
            cfg_word_pins <= c;
            presetn <= 1'b0;
            repeat (4) @(posedge pclk);
            presetn <= 1'b1;
            hold(1'b0, 9000);
        end
    endtask
    task results;
        begin
            if (err_count == 0 && comparisons > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    // Hang guard, well past the expected run length
    initial begin
        #1000000;
        err_count = err_count + 1;
        results;
    end
    initial begin
        cfgs = '{4'hD, 4'h4, 4'h5, 4'h6, 4'hF, 4'h7};
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        cfg_word_pins = 4'h7;
        err_count = 0;
        comparisons = 0;
        for (i = 0; i < 6; i = i + 1) begin
            boot(cfgs[i]);
            lo = (cfgs[i][3] ? PWR : 0) + (cfgs[i][1:0] != 2'h3 ? OSTN * 4 - 8 : 0);
            span(lo, lo + 48);
            apb(1'b0, CFG, 32'h0);
            chk(rd, {28'h0, cfgs[i]});
            apb(1'b0, OPT, 32'h0);
            chk(rd, 32'hFF);
        end
        // Read-only place and an unmapped one
        apb(1'b1, CFG, 32'h0);
        apb(1'b0, CFG, 32'h0);
        chk(rd, 32'h7);
        apb(1'b0, 16'h0300, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // Every rate code, then prescaler taken away
        for (i = 0; i < 9; i = i + 1) begin
            apb(1'b1, OPT, i < 8 ? 32'h8 + i : 32'h7);
            apb(1'b1, CTRL, 32'h1);
            hold(1'b1, 7000);
            lo = i < 8 ? BASE << i : BASE;
            span(lo - 4, lo + lo / BASE + 8);
            hold(1'b0, 10);
            apb(1'b0, STAT, 32'h0);
            chk(rd & 32'h3, 32'h2);
        end
        apb(1'b0, OPT, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b1, OPT, 32'h0);
        repeat (6) begin
            apb(1'b1, CTRL, 32'h1);
            repeat (30) @(posedge pclk);
        end
        apb(1'b0, STAT, 32'h0);
        chk(rd & 32'h3, 32'h3);
        // Sleep, then wake by the watchdog with its interrupt
        apb(1'b1, ICLR, 32'h7);
        apb(1'b1, IEN, 32'h2);
        apb(1'b1, CTRL, 32'h2);
        @(posedge pclk);
        chk({31'h0, asleep_r}, 32'h1);
        n = 0;
        while (asleep_r === 1'b1 && n < 200) begin
            @(posedge pclk);
            n = n + 1;
        end
        span(BASE - 8, BASE + 10);
        apb(1'b0, STAT, 32'h0);
        chk(rd & 32'h3, 32'h0);
        apb(1'b1, CTRL, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, IEN, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, IEN, 32'h2);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ICLR, 32'h2);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Sleep, then wake by command before any timeout
        apb(1'b1, CTRL, 32'h2);
        chk({31'h0, asleep_r}, 32'h1);
        apb(1'b1, CTRL, 32'h4);
        chk({31'h0, asleep_r}, 32'h0);
        apb(1'b0, STAT, 32'h0);
        chk(rd & 32'h3, 32'h1);
        // Watchdog fused off stays quiet
        boot(4'h3);
        apb(1'b1, OPT, 32'h0);
        repeat (200) @(posedge pclk);
        apb(1'b0, STAT, 32'h0);
        chk(rd & 32'h21, 32'h1);
        apb(1'b0, OPT, 32'h0);
        chk(rd, 32'h0);
        results;
    end
endmodule
`default_nettype wire
